// ---- hw/swk_fd_cfg_regs.sv ----
// Purpose: Wake payload bytes, FD tolerant config, trim, options, calibration
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes: Unlock key lives in a local register at the chosen unlock offset
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Two writable bytes hold expected wake payload bytes one and zero.
// - Config bit 0 enables FD tolerant mode.
// - Error counter suspended during wake only if inhibit and FD enable set.
// - Hardware clears error-count inhibit when bus silence timeout expires.
// - Config bit 4 routes bus data around the analog receiver filter.
// - Filter code 0 to 6 gives 50 to 350 ns; code 7 700 ns.
// - Dominant pulse filter stays active regardless of filter bypass.
// - Reserved config bits 7:6 and options bits 6:5 read zero.
// - Trim field writable only while unlock field holds 11.
// - Options bit 7 selects wake receiver; writable only when unlocked.
// - Reset selects the low-power wake receiver.
// - Calibration high and low bytes are read-only.
module swk_fd_cfg_regs (
    input wire logic clk,
    input wire logic rst,
    input wire swk_cfg_pkg::bus_req_s req,
    output logic [swk_cfg_pkg::DATA_W-1:0] rdata,
    input wire logic [swk_cfg_pkg::DATA_W-1:0] cal_high,
    input wire logic [swk_cfg_pkg::DATA_W-1:0] cal_low,
    input wire logic silence_expired,
    input wire logic wake_active,
    input wire logic bus_rx_raw,
    input wire logic bus_rx_filtered,
    input wire swk_cfg_pkg::frame_bytes_s frame,
    output logic fd_tolerant_enable,
    output logic rx_analog_filter_bypass,
    output logic [2:0] dominant_pulse_filter_time,
    output logic error_counter_suspend,
    output logic wake_receiver_select,
    output logic [6:0] osc_trim,
    output logic rx_filtered_data,
    output logic payload_match
);
    import swk_cfg_pkg::*;

    // ==========================================================
    // Register state
    logic [7:0] payload_byte_one, next_payload_byte_one;
    logic [7:0] payload_byte_zero, next_payload_byte_zero;
    logic fd_en, next_fd_en;
    logic [2:0] filt, next_filt;
    logic byp, next_byp;
    logic error_count_inhibit, next_error_count_inhibit;
    logic [6:0] trim, next_trim;
    logic trim_rsv, next_trim_rsv;
    logic rx_sel, next_rx_sel;
    logic [4:0] opt_rsv, next_opt_rsv;
    logic [1:0] unlock, next_unlock;
    logic [7:0] next_rdata;
    logic unlocked;

    function automatic logic hit(input bus_req_s r, input logic [6:0] ofs);
        hit = r.wr && (r.addr == ofs);
    endfunction

    // Filter length in clock cycles, rounded up, at least one
    function automatic logic [3:0] filt_cycles(input logic [2:0] code);
        int ns;
        ns = (code == FILT_LONG_CODE) ? FILT_LONG_NS : (int'(code) + 1) * FILT_STEP_NS;
        filt_cycles = 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    endfunction

    assign unlocked = (unlock == UNLOCK_KEY);

    always_comb begin
        next_payload_byte_one = payload_byte_one;
        next_payload_byte_zero = payload_byte_zero;
        next_fd_en = fd_en;
        next_filt = filt;
        next_byp = byp;
        next_error_count_inhibit = error_count_inhibit;
        next_trim = trim;
        next_trim_rsv = trim_rsv;
        next_rx_sel = rx_sel;
        next_opt_rsv = opt_rsv;
        next_unlock = unlock;
        if (hit(req, OFS_PAYLOAD1)) begin
            next_payload_byte_one = req.wdata;
        end
        if (hit(req, OFS_PAYLOAD0)) begin
            next_payload_byte_zero = req.wdata;
        end
        if (hit(req, OFS_FD_CFG)) begin
            next_fd_en = req.wdata[FD_EN_BIT];
            next_filt = req.wdata[FILT_HI:FILT_LO];
            next_byp = req.wdata[BYP_BIT];
            next_error_count_inhibit = req.wdata[INH_BIT];
        end
        if (silence_expired) begin
            next_error_count_inhibit = 1'b0;
        end
        if (hit(req, OFS_TRIM)) begin
            next_trim_rsv = req.wdata[RXSEL_BIT];
            if (unlocked) begin
                next_trim = req.wdata[TRIM_HI:0];
            end
        end
        if (hit(req, OFS_OPTIONS)) begin
            next_opt_rsv = req.wdata[PRESET_HI:0];
            if (unlocked) begin
                next_rx_sel = req.wdata[RXSEL_BIT];
            end
        end
        if (hit(req, OFS_UNLOCK)) begin
            next_unlock = req.wdata[1:0];
        end
    end

    always_comb begin
        next_rdata = RST_ZERO;
        if (req.rd) begin
            unique case (req.addr)
                OFS_PAYLOAD1: next_rdata = payload_byte_one;
                OFS_PAYLOAD0: next_rdata = payload_byte_zero;
                OFS_FD_CFG: next_rdata = {2'h0, error_count_inhibit, byp, filt, fd_en};
                OFS_TRIM: next_rdata = {trim_rsv, trim};
                OFS_OPTIONS: next_rdata = {rx_sel, 2'h0, opt_rsv};
                OFS_CAL_HIGH: next_rdata = cal_high;
                OFS_CAL_LOW: next_rdata = cal_low;
                OFS_UNLOCK: next_rdata = {6'h00, unlock};
                default: next_rdata = RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            payload_byte_one <= RST_ZERO;
            payload_byte_zero <= RST_ZERO;
            fd_en <= 1'b0;
            filt <= 3'h0;
            byp <= 1'b0;
            error_count_inhibit <= 1'b0;
            trim <= TRIM_PRESET;
            trim_rsv <= TRIM_RSV_PRESET;
            rx_sel <= 1'b0;
            opt_rsv <= OPT_PRESET;
            unlock <= 2'h0;
            rdata <= RST_ZERO;
        end else begin
            payload_byte_one <= next_payload_byte_one;
            payload_byte_zero <= next_payload_byte_zero;
            fd_en <= next_fd_en;
            filt <= next_filt;
            byp <= next_byp;
            error_count_inhibit <= next_error_count_inhibit;
            trim <= next_trim;
            trim_rsv <= next_trim_rsv;
            rx_sel <= next_rx_sel;
            opt_rsv <= next_opt_rsv;
            unlock <= next_unlock;
            rdata <= next_rdata;
        end
    end

    assign fd_tolerant_enable = fd_en;
    assign rx_analog_filter_bypass = byp;
    assign dominant_pulse_filter_time = filt;
    assign wake_receiver_select = rx_sel;
    assign osc_trim = trim;
    assign error_counter_suspend = wake_active && fd_en && error_count_inhibit;

    // ==========================================================
    // Dominant pulse filter after the bypass mux
    logic raw_s1, raw_s2, ana_s1, ana_s2, rx_mux, filt_out, next_filt_out;
    logic [3:0] dom_cnt, next_dom_cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            raw_s1 <= 1'b1;
            raw_s2 <= 1'b1;
            ana_s1 <= 1'b1;
            ana_s2 <= 1'b1;
        end else begin
            raw_s1 <= bus_rx_raw;
            raw_s2 <= raw_s1;
            ana_s1 <= bus_rx_filtered;
            ana_s2 <= ana_s1;
        end
    end
    assign rx_mux = byp ? raw_s2 : ana_s2;

    always_comb begin
        next_dom_cnt = dom_cnt;
        next_filt_out = filt_out;
        if (rx_mux) begin
            next_dom_cnt = 4'h0;
            next_filt_out = 1'b1;
        end else if (dom_cnt + 4'h1 >= filt_cycles(filt)) begin
            next_filt_out = 1'b0;
        end else begin
            next_dom_cnt = dom_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dom_cnt <= 4'h0;
            filt_out <= 1'b1;
        end else begin
            dom_cnt <= next_dom_cnt;
            filt_out <= next_filt_out;
        end
    end
    assign rx_filtered_data = filt_out;

    // ==========================================================
    // Payload compare
    logic frame_match, next_frame_match;
    always_comb begin
        next_frame_match = frame_match;
        if (frame.valid) begin
            next_frame_match = (frame.byte1 == payload_byte_one) && (frame.byte0 == payload_byte_zero);
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_match <= 1'b0;
        end else begin
            frame_match <= next_frame_match;
        end
    end
    assign payload_match = frame_match;

    // ==========================================================
    // Checks
    inhibit_clear_a: assert property (@(posedge clk) disable iff (rst)
        silence_expired |=> !error_count_inhibit)
        else $error("inhibit not cleared on silence");
    suspend_gate_a: assert property (@(posedge clk) disable iff (rst)
        error_counter_suspend |-> (fd_en && error_count_inhibit && wake_active))
        else $error("suspend without enable");
    trim_lock_a: assert property (@(posedge clk) disable iff (rst)
        !unlocked |=> $stable(trim))
        else $error("trim changed while locked");
    rxsel_lock_a: assert property (@(posedge clk) disable iff (rst)
        (!unlocked || !hit(req, OFS_OPTIONS)) |=> $stable(rx_sel))
        else $error("receiver select changed while locked");
    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        (req.rd && req.addr == OFS_FD_CFG) |=> (rdata[7:6] == 2'h0))
        else $error("config reserved bits nonzero");
    reserved_opt_a: assert property (@(posedge clk) disable iff (rst)
        (req.rd && req.addr == OFS_OPTIONS) |=> (rdata[6:5] == 2'h0))
        else $error("options reserved bits nonzero");
    rx_select_reset_a: assert property (@(posedge clk)
        $fell(rst) |-> !wake_receiver_select)
        else $error("receiver select not low-power after reset");
    bypass_store_a: assert property (@(posedge clk) disable iff (rst)
        hit(req, OFS_FD_CFG) |=> rx_analog_filter_bypass == $past(req.wdata[BYP_BIT]))
        else $error("bypass not stored");
    filter_code_a: assert property (@(posedge clk) disable iff (rst)
        hit(req, OFS_FD_CFG) |=> dominant_pulse_filter_time == $past(req.wdata[FILT_HI:FILT_LO]))
        else $error("filter code not stored");
    fd_enable_a: assert property (@(posedge clk) disable iff (rst)
        hit(req, OFS_FD_CFG) && !silence_expired |=> fd_tolerant_enable == $past(req.wdata[FD_EN_BIT]))
        else $error("fd enable not stored");
    payload_wr_a: assert property (@(posedge clk) disable iff (rst)
        hit(req, OFS_PAYLOAD1) |=> payload_byte_one == $past(req.wdata))
        else $error("payload byte one not stored");
    payload0_wr_a: assert property (@(posedge clk) disable iff (rst)
        hit(req, OFS_PAYLOAD0) |=> payload_byte_zero == $past(req.wdata))
        else $error("payload byte zero not stored");
    match_compare_a: assert property (@(posedge clk) disable iff (rst)
        frame.valid |=> payload_match == (($past(frame.byte1) == $past(payload_byte_one))
            && ($past(frame.byte0) == $past(payload_byte_zero))))
        else $error("payload compare wrong");
    cal_high_read_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == OFS_CAL_HIGH |=> rdata == $past(cal_high))
        else $error("calibration high misread");
    cal_read_a: assert property (@(posedge clk) disable iff (rst)
        req.rd && req.addr == OFS_CAL_LOW |=> rdata == $past(cal_low))
        else $error("calibration low misread");
    filter_min_a: assert property (@(posedge clk) disable iff (rst)
        $fell(filt_out) |-> !$past(rx_mux))
        else $error("filter passed short pulse");
    filter_rise_a: assert property (@(posedge clk) disable iff (rst)
        $rose(filt_out) |-> $past(rx_mux))
        else $error("filter rose without recessive sample");
    // Run of consecutive dominant samples
    logic [3:0] dom_run, next_dom_run;
    always_comb begin
        next_dom_run = 4'h0;
        if (!rx_mux && dom_run != 4'hF) begin
            next_dom_run = dom_run + 4'h1;
        end else if (!rx_mux) begin
            next_dom_run = dom_run;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            dom_run <= 4'h0;
        end else begin
            dom_run <= next_dom_run;
        end
    end
    filter_run_a: assert property (@(posedge clk) disable iff (rst)
        $fell(filt_out) |-> (dom_run >= filt_cycles($past(filt))))
        else $error("filter fell before the minimum run");
    cover_unlock_c: cover property (@(posedge clk) disable iff (rst) unlocked && hit(req, OFS_TRIM));
    cover_match_c: cover property (@(posedge clk) disable iff (rst) frame.valid ##1 payload_match);
    cover_suspend_c: cover property (@(posedge clk) disable iff (rst) error_counter_suspend ##1 silence_expired);
    cover_filter_c: cover property (@(posedge clk) disable iff (rst) byp ##1 $fell(filt_out));
endmodule
`default_nettype wire

// ---- hw/swk_cfg_pkg.sv ----
// Purpose: Constants and carriers for the selective wake configuration slice
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Offsets are the register indices of the slice
package swk_cfg_pkg;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [6:0] OFS_PAYLOAD1 = 7'h32;
    localparam logic [6:0] OFS_PAYLOAD0 = 7'h33;
    localparam logic [6:0] OFS_FD_CFG = 7'h34;
    localparam logic [6:0] OFS_TRIM = 7'h38;
    localparam logic [6:0] OFS_OPTIONS = 7'h39;
    localparam logic [6:0] OFS_CAL_HIGH = 7'h3A;
    localparam logic [6:0] OFS_CAL_LOW = 7'h3B;
    localparam logic [6:0] OFS_UNLOCK = 7'h3F;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [1:0] UNLOCK_KEY = 2'h3;
    localparam int FD_EN_BIT = 0;
    localparam int FILT_LO = 1;
    localparam int FILT_HI = 3;
    localparam int BYP_BIT = 4;
    localparam int INH_BIT = 5;
    localparam int RXSEL_BIT = 7;
    localparam int TRIM_HI = 6;
    localparam int PRESET_HI = 4;
    localparam logic [2:0] FILT_LONG_CODE = 3'h7;
    localparam int FILT_STEP_NS = 50;
    localparam int FILT_LONG_NS = 700;
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [6:0] TRIM_PRESET = 7'h40;
    localparam logic [4:0] OPT_PRESET = 5'h00;
    localparam logic TRIM_RSV_PRESET = 1'b0;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
    typedef struct packed {
        logic [DATA_W-1:0] byte1;
        logic [DATA_W-1:0] byte0;
        logic valid;
    } frame_bytes_s;
endpackage

// ---- verif/can_node_model.sv ----
// Purpose: Far-side bus node making dominant pulses
// Assumes: Bus idles recessive (1) through termination
// Notes: Analog path passes only pulses of 8 cycles or more
`timescale 1ns/1ns
`default_nettype none
module can_node_model (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] dom_len,
    output logic rx_raw,
    output logic rx_analog
);
    int left = 0;
    always @(posedge clk) begin
        if (go) left <= int'(dom_len);
        else if (left > 0) left <= left - 1;
    end
    assign rx_raw = (left == 0);
    assign rx_analog = rx_raw | (dom_len < 4'h8);
endmodule
`default_nettype wire

// ---- verif/swk_fd_cfg_regs_bench.sv ----
// Purpose: Self-checking bench for the wake config slice
// Assumes: Plain strobe bus, read data one cycle after strobe
// Notes: Software side keeps trim and options reserved fields at preset
`timescale 1ns/1ns
`default_nettype none
module swk_fd_cfg_regs_bench;
    import swk_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bus_req_s req = '0;
    frame_bytes_s frame = '0;
    logic silence = 1'b0;
    logic wake = 1'b0;
    logic go = 1'b0;
    logic [3:0] dom_len = 4'h0;
    logic rx_raw, rx_analog, fd_en, byp, susp, wrs, rxf, pm;
    logic [2:0] dpf;
    logic [6:0] trim;
    logic [7:0] rdata;
    int errors = 0;
    int checked = 0;
    always #50 clk = ~clk;
    // ========================================
    // Instances
    swk_fd_cfg_regs DUT (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .cal_high(8'hC3), .cal_low(8'h3C), .silence_expired(silence),
        .wake_active(wake), .bus_rx_raw(rx_raw), .bus_rx_filtered(rx_analog),
        .frame(frame), .fd_tolerant_enable(fd_en), .rx_analog_filter_bypass(byp),
        .dominant_pulse_filter_time(dpf), .error_counter_suspend(susp),
        .wake_receiver_select(wrs), .osc_trim(trim), .rx_filtered_data(rxf),
        .payload_match(pm));
    can_node_model node (.clk(clk), .go(go), .dom_len(dom_len), .rx_raw(rx_raw), .rx_analog(rx_analog));
    // ========================================
    // Tasks
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic frm(input logic [7:0] b1, input logic [7:0] b0, input logic e);
        @(posedge clk);
        frame <= '{byte1: b1, byte0: b0, valid: 1'b1};
        @(posedge clk);
        frame.valid <= 1'b0;
        @(posedge clk);
        #1 chk("payload_match", {7'h0, e}, {7'h0, pm});
    endtask
    task automatic pulse(input logic bp, input logic [2:0] c, input logic [3:0] n, input logic e);
        logic fell;
        wr(OFS_FD_CFG, {3'b000, bp, c, 1'b1});
        fell = 1'b0;
        @(posedge clk);
        dom_len <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (int'(n) + 6) begin
            @(posedge clk);
            #1 if (rxf === 1'b0) fell = 1'b1;
        end
        chk("filtered fall", {7'h0, e}, {7'h0, fell});
    endtask
    task automatic t_regs;
        rd(OFS_PAYLOAD1, 8'h00);
        rd(OFS_FD_CFG, 8'h00);
        rd(OFS_TRIM, {TRIM_RSV_PRESET, TRIM_PRESET});
        rd(OFS_OPTIONS, {3'b000, OPT_PRESET});
        chk("rx select", 8'h00, {7'h0, wrs});
        rd(7'h35, 8'h00);
        wr(OFS_PAYLOAD1, 8'hA5);
        wr(OFS_PAYLOAD0, 8'h5A);
        rd(OFS_PAYLOAD1, 8'hA5);
        rd(OFS_PAYLOAD0, 8'h5A);
        @(posedge clk);
        #1 chk("rdata idle", 8'h00, rdata);
        frm(8'hA5, 8'h5A, 1'b1);
        frm(8'hA5, 8'h5B, 1'b0);
    endtask
    task automatic t_fd;
        wr(OFS_FD_CFG, 8'hFF);
        rd(OFS_FD_CFG, 8'h3F);
        chk("fields", 8'h1F, {3'b000, byp, dpf, fd_en});
        @(posedge clk);
        wake <= 1'b1;
        #1 chk("suspend on", 8'h01, {7'h0, susp});
        wr(OFS_FD_CFG, 8'h3E);
        chk("suspend fd off", 8'h00, {7'h0, susp});
        wr(OFS_FD_CFG, 8'h21);
        chk("suspend armed", 8'h01, {7'h0, susp});
        @(posedge clk);
        silence <= 1'b1;
        @(posedge clk);
        silence <= 1'b0;
        rd(OFS_FD_CFG, 8'h01);
        chk("suspend cleared", 8'h00, {7'h0, susp});
        @(posedge clk);
        wake <= 1'b0;
    endtask
    task automatic t_lock;
        wr(OFS_TRIM, 8'h15);
        rd(OFS_TRIM, 8'h40);
        wr(OFS_OPTIONS, 8'h80);
        rd(OFS_OPTIONS, 8'h00);
        wr(OFS_UNLOCK, {6'h00, UNLOCK_KEY});
        wr(OFS_TRIM, 8'h15);
        rd(OFS_TRIM, 8'h15);
        chk("osc_trim", 8'h15, {1'b0, trim});
        wr(OFS_OPTIONS, 8'hE0);
        rd(OFS_OPTIONS, 8'h80);
        chk("rx select", 8'h01, {7'h0, wrs});
        wr(OFS_CAL_HIGH, 8'hFF);
        wr(OFS_CAL_LOW, 8'h00);
        rd(OFS_CAL_HIGH, 8'hC3);
        rd(OFS_CAL_LOW, 8'h3C);
        wr(OFS_UNLOCK, 8'h00);
        wr(OFS_OPTIONS, 8'h00);
        rd(OFS_OPTIONS, 8'h80);
        wr(OFS_TRIM, 8'h7F);
        rd(OFS_TRIM, 8'h15);
    endtask
    task automatic t_filter;
        pulse(1'b0, 3'h0, 4'h3, 1'b0);
        pulse(1'b1, 3'h0, 4'h1, 1'b1);
        pulse(1'b1, 3'h3, 4'h1, 1'b0);
        pulse(1'b1, 3'h3, 4'h2, 1'b1);
        pulse(1'b1, 3'h7, 4'h6, 1'b0);
        pulse(1'b1, 3'h7, 4'h7, 1'b1);
        pulse(1'b0, 3'h7, 4'h9, 1'b1);
    endtask
    task automatic test_done;
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ========================================
    // Sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_fd;
        t_lock;
        t_filter;
        test_done;
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        test_done;
    end
endmodule
`default_nettype wire
